/* design/rcs_top.sv */
// Behaviour
// - service countdown runs only while interval is nonzero, from the write.
// - expired service request is kept in non-volatile storage.
// - expiry raises warning, unload or alarm anomaly as selected.
// - alarm class blocks generator use until request cleared.
// - rewriting interval cancels request; zero disables, any value restarts. Here an expiry in the same cycle still sets the request.
// - active energy counts only delivered power with breaker closed.
// - reactive energy counts absolute value with breaker closed.
// - only partial energy, starts, partial hours, load hours clear.
// - every counter, powered time too, is readable by the host.
// - counters saved all together, only on save events.
// - save once engine confirmed running, not per attempt.
// - save when engine recognised stopped.
// - save on each whole-hour step of engine or load hours.
// - save when mode enters off/reset.
// - save once for every powered hour.
// - save on interval change and on any counter clear.
// - minute fractions are saved with the integer parts.
// - test day mask bit 0 Sunday up to bit 6 Saturday.
// - test runs from set hour:minute for set minutes, every selected day.
// - test run starts regardless of recent engine use.
// - auto start allowed only on masked days inside one shared window.
// - start above end means window crosses midnight into next day.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module rcs_top #(
  parameter int CNT_W = 32,
  parameter int MIN_TICK_CYCLES = 600000000
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic minute_tick,
  input wire logic [2:0] rtc_weekday,
  input wire logic [10:0] rtc_minute_of_day,
  input wire logic generator_breaker,
  input wire logic engine_running,
  input wire logic [15:0] p_active,
  input wire logic [15:0] q_reactive,
  input wire logic mode_off_reset,
  input wire logic mains_fail_start_req,
  output logic nvm_save,
  output logic service_pending,
  output logic anomaly_warning,
  output logic anomaly_unload,
  output logic anomaly_alarm,
  output logic gen_inhibit,
  output logic test_run,
  output logic auto_start
);

  if (CNT_W < 17 || CNT_W > 32 || MIN_TICK_CYCLES < 1)
  begin : g_bad_params
    $error("rcs_top: unsupported parameters");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync_d;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync_d <= 5'h00;
    end
    else
    begin
      sync1 <= {minute_tick, generator_breaker, engine_running, mode_off_reset,
                mains_fail_start_req};
      sync2 <= sync1;
      sync_d <= sync2;
    end
  end
  logic tick_s;
  logic brk_s;
  logic run_s;
  logic off_s;
  logic mains_s;
  assign tick_s = sync2[4] & ~sync_d[4];
  assign brk_s = sync2[3];
  assign run_s = sync2[2];
  assign off_s = sync2[1];
  assign mains_s = sync2[0];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic wr;
  logic [1:0] act_sel;
  logic [CNT_W-1:0] svc_ivl;
  logic [CNT_W-1:0] svc_left;
  logic [6:0] test_days;
  logic [10:0] test_start;
  logic [15:0] test_dur;
  logic [6:0] auto_days;
  logic [10:0] auto_start_t;
  logic [10:0] auto_end_t;
  logic [4:0] clr;
  assign wr = psel & penable & pwrite & pready;
  assign clr = (wr && paddr == rcs_pkg::OFF_CLEAR) ? pwdata[4:0] : 5'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_sel <= rcs_pkg::ACT_WARN;
      test_days <= 7'h00;
      test_start <= 11'h000;
      test_dur <= 16'h0000;
      auto_days <= 7'h00;
      auto_start_t <= 11'h000;
      auto_end_t <= 11'h000;
    end
    else if (wr)
    begin
      case (paddr)
        rcs_pkg::OFF_CTRL: act_sel <= pwdata[rcs_pkg::CTRL_ACT_LSB +: 2];
        rcs_pkg::OFF_TEST_DAYS: test_days <= pwdata[6:0];
        rcs_pkg::OFF_TEST_START: test_start <= pwdata[10:0];
        rcs_pkg::OFF_TEST_DUR: test_dur <= pwdata[15:0];
        rcs_pkg::OFF_AUTO_DAYS: auto_days <= pwdata[6:0];
        rcs_pkg::OFF_AUTO_START: auto_start_t <= pwdata[10:0];
        rcs_pkg::OFF_AUTO_END: auto_end_t <= pwdata[10:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // minute base and counters
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] kwh_part;
  logic [CNT_W-1:0] kwh_tot;
  logic [CNT_W-1:0] kvarh_part;
  logic [CNT_W-1:0] kvarh_tot;
  logic [CNT_W-1:0] starts;
  logic [CNT_W-1:0] eng_part;
  logic [CNT_W-1:0] eng_tot;
  logic [CNT_W-1:0] load_hrs;
  logic [CNT_W-1:0] pwr_hrs;
  logic [5:0] eng_min;
  logic [5:0] load_min;
  logic [5:0] pwr_min;
  logic [15:0] q_abs;
  logic run_d;
  logic eng_hour;
  logic load_hour;
  logic pwr_hour;
  assign q_abs = q_reactive[15] ? 16'(-q_reactive) : q_reactive;
  assign eng_hour = tick_s && run_s && eng_min == 6'(rcs_pkg::MIN_PER_HOUR - 1);
  assign load_hour = tick_s && brk_s && load_min == 6'(rcs_pkg::MIN_PER_HOUR - 1);
  assign pwr_hour = tick_s && pwr_min == 6'(rcs_pkg::MIN_PER_HOUR - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      kwh_part <= '0;
      kwh_tot <= '0;
    end
    else
    begin
      if (clr[rcs_pkg::CLR_KWH])
        kwh_part <= '0;
      else if (tick_s && brk_s && !p_active[15])
        kwh_part <= kwh_part + CNT_W'(p_active);
      if (tick_s && brk_s && !p_active[15])
        kwh_tot <= kwh_tot + CNT_W'(p_active);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      kvarh_part <= '0;
      kvarh_tot <= '0;
    end
    else
    begin
      if (clr[rcs_pkg::CLR_KVARH])
        kvarh_part <= '0;
      else if (tick_s && brk_s)
        kvarh_part <= kvarh_part + CNT_W'(q_abs);
      if (tick_s && brk_s)
        kvarh_tot <= kvarh_tot + CNT_W'(q_abs);
    end
  end

  // hour counters with minute fractions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      starts <= '0;
      run_d <= 1'b0;
      eng_part <= '0;
      eng_tot <= '0;
      eng_min <= 6'h00;
      load_hrs <= '0;
      load_min <= 6'h00;
      pwr_hrs <= '0;
      pwr_min <= 6'h00;
    end
    else
    begin
      run_d <= run_s;
      if (clr[rcs_pkg::CLR_STARTS])
        starts <= '0;
      else if (run_s && !run_d)
        starts <= starts + CNT_W'(1);
      if (tick_s && run_s)
        eng_min <= eng_hour ? 6'h00 : eng_min + 6'h01;
      if (clr[rcs_pkg::CLR_ENG])
        eng_part <= '0;
      else if (eng_hour)
        eng_part <= eng_part + CNT_W'(1);
      if (eng_hour)
        eng_tot <= eng_tot + CNT_W'(1);
      if (clr[rcs_pkg::CLR_LOAD])
      begin
        load_hrs <= '0;
        load_min <= 6'h00;
      end
      else if (tick_s && brk_s)
      begin
        load_min <= load_hour ? 6'h00 : load_min + 6'h01;
        if (load_hour)
          load_hrs <= load_hrs + CNT_W'(1);
      end
      if (tick_s)
        pwr_min <= pwr_hour ? 6'h00 : pwr_min + 6'h01;
      if (pwr_hour)
        pwr_hrs <= pwr_hrs + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // service countdown
  // ----------------------------------------------------------------
  logic ivl_wr;
  logic svc_hour;
  assign ivl_wr = wr && paddr == rcs_pkg::OFF_SVC_IVL;
  assign svc_hour = eng_hour && svc_ivl != '0 && !service_pending;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      svc_ivl <= '0;
      svc_left <= '0;
      service_pending <= 1'b0;
    end
    else if (ivl_wr)
    begin
      svc_ivl <= pwdata[CNT_W-1:0];
      svc_left <= pwdata[CNT_W-1:0];
      // expiry in the same cycle wins over the cancel
      service_pending <= svc_hour && svc_left == CNT_W'(1);
    end
    else if (svc_hour)
    begin
      svc_left <= svc_left - CNT_W'(1);
      if (svc_left == CNT_W'(1))
        service_pending <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      anomaly_warning <= 1'b0;
      anomaly_unload <= 1'b0;
      anomaly_alarm <= 1'b0;
      gen_inhibit <= 1'b0;
    end
    else
    begin
      anomaly_warning <= service_pending && act_sel == rcs_pkg::ACT_WARN;
      anomaly_unload <= service_pending && act_sel == rcs_pkg::ACT_UNLOAD;
      anomaly_alarm <= service_pending && act_sel == rcs_pkg::ACT_ALARM;
      gen_inhibit <= service_pending && act_sel == rcs_pkg::ACT_ALARM;
    end
  end

  // ----------------------------------------------------------------
  // save events
  // ----------------------------------------------------------------
  logic off_d;
  logic [CNT_W-1:0] save_cnt;
  logic save_ev;
  assign save_ev = (run_s && !run_d)        // confirmed running
                 | (!run_s && run_d)        // recognised stopped
                 | eng_hour | load_hour     // hour steps
                 | (off_s && !off_d)        // off/reset entry
                 | pwr_hour                 // powered hour
                 | ivl_wr | (clr != 5'h00)  // setting or clear
                 | svc_hour;                // service countdown step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      off_d <= 1'b0;
      nvm_save <= 1'b0;
      save_cnt <= '0;
    end
    else
    begin
      off_d <= off_s;
      nvm_save <= save_ev;
      if (save_ev)
        save_cnt <= save_cnt + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // weekly scheduler
  // ----------------------------------------------------------------
  logic [6:0] day_bit;
  logic [6:0] prev_day_bit;
  logic [16:0] test_end;
  logic in_test;
  logic in_auto;
  assign day_bit = 7'(rcs_pkg::SUNDAY_MASK << rtc_weekday);
  assign prev_day_bit = {day_bit[5:0], day_bit[6]} == 7'h00 ? 7'h00 :
                        {day_bit[0], day_bit[6:1]};
  assign test_end = 17'(test_start) + 17'(test_dur);
  assign in_test = |(test_days & day_bit) && test_dur != 16'h0000 &&
                   rtc_minute_of_day >= test_start &&
                   17'(rtc_minute_of_day) < test_end;
  assign in_auto = (auto_start_t <= auto_end_t) ?
      (|(auto_days & day_bit) && rtc_minute_of_day >= auto_start_t &&
       rtc_minute_of_day < auto_end_t) :
      ((|(auto_days & day_bit) && rtc_minute_of_day >= auto_start_t) ||
       (|(auto_days & prev_day_bit) && rtc_minute_of_day < auto_end_t));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      test_run <= 1'b0;
      auto_start <= 1'b0;
    end
    else
    begin
      test_run <= in_test;
      auto_start <= mains_s && in_auto;
    end
  end

  // ----------------------------------------------------------------
  // apb read
  // ----------------------------------------------------------------
  logic [31:0] rd;
  always_comb
  begin
    rd = 32'h0000_0000;
    case (paddr)
      rcs_pkg::OFF_CTRL: rd = 32'(act_sel);
      rcs_pkg::OFF_SVC_IVL: rd = 32'(svc_ivl);
      rcs_pkg::OFF_SVC_LEFT: rd = 32'(svc_left);
      rcs_pkg::OFF_STATUS: rd = 32'({in_auto, test_run, gen_inhibit, anomaly_alarm,
                                     anomaly_unload, anomaly_warning, service_pending});
      rcs_pkg::OFF_TEST_DAYS: rd = 32'(test_days);
      rcs_pkg::OFF_TEST_START: rd = 32'(test_start);
      rcs_pkg::OFF_TEST_DUR: rd = 32'(test_dur);
      rcs_pkg::OFF_AUTO_DAYS: rd = 32'(auto_days);
      rcs_pkg::OFF_AUTO_START: rd = 32'(auto_start_t);
      rcs_pkg::OFF_AUTO_END: rd = 32'(auto_end_t);
      rcs_pkg::OFF_SAVE_CNT: rd = 32'(save_cnt);
      rcs_pkg::OFF_KWH_PART: rd = 32'(kwh_part);
      rcs_pkg::OFF_KWH_TOT: rd = 32'(kwh_tot);
      rcs_pkg::OFF_KVARH_PART: rd = 32'(kvarh_part);
      rcs_pkg::OFF_KVARH_TOT: rd = 32'(kvarh_tot);
      rcs_pkg::OFF_STARTS: rd = 32'(starts);
      rcs_pkg::OFF_ENG_PART: rd = 32'(eng_part);
      rcs_pkg::OFF_ENG_TOT: rd = 32'(eng_tot);
      rcs_pkg::OFF_LOAD_HRS: rd = 32'(load_hrs);
      rcs_pkg::OFF_PWR_HRS: rd = 32'(pwr_hrs);
      rcs_pkg::OFF_FRAC: rd = 32'({pwr_min, load_min, eng_min});
      default: rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > rcs_pkg::OFF_FRAC;
      if (psel && !penable)
        prdata <= rd;
    end
  end

endmodule : rcs_top

`default_nettype wire

/* design/rcs_pkg.sv */
package rcs_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SVC_IVL = 8'h04;
  localparam logic [7:0] OFF_SVC_LEFT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_TEST_DAYS = 8'h10;
  localparam logic [7:0] OFF_TEST_START = 8'h14;
  localparam logic [7:0] OFF_TEST_DUR = 8'h18;
  localparam logic [7:0] OFF_AUTO_DAYS = 8'h1C;
  localparam logic [7:0] OFF_AUTO_START = 8'h20;
  localparam logic [7:0] OFF_AUTO_END = 8'h24;
  localparam logic [7:0] OFF_CLEAR = 8'h28;
  localparam logic [7:0] OFF_SAVE_CNT = 8'h2C;
  localparam logic [7:0] OFF_KWH_PART = 8'h30;
  localparam logic [7:0] OFF_KWH_TOT = 8'h34;
  localparam logic [7:0] OFF_KVARH_PART = 8'h38;
  localparam logic [7:0] OFF_KVARH_TOT = 8'h3C;
  localparam logic [7:0] OFF_STARTS = 8'h40;
  localparam logic [7:0] OFF_ENG_PART = 8'h44;
  localparam logic [7:0] OFF_ENG_TOT = 8'h48;
  localparam logic [7:0] OFF_LOAD_HRS = 8'h4C;
  localparam logic [7:0] OFF_PWR_HRS = 8'h50;
  localparam logic [7:0] OFF_FRAC = 8'h54;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ACT_LSB = 0;
  localparam int CLR_KWH = 0;
  localparam int CLR_KVARH = 1;
  localparam int CLR_STARTS = 2;
  localparam int CLR_ENG = 3;
  localparam int CLR_LOAD = 4;
  localparam int ST_SVC_PEND = 0;
  localparam int ST_ANOM_LSB = 1;
  localparam int ST_INHIBIT = 4;
  localparam int ST_TEST = 5;
  localparam int ST_AUTO_OK = 6;

  // ----------------------------------------------------------------
  // expiry action codes, anomaly one-hot order: warning, unload, alarm
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_WARN = 2'h0;
  localparam logic [1:0] ACT_UNLOAD = 2'h1;
  localparam logic [1:0] ACT_ALARM = 2'h2;

  localparam int MIN_PER_HOUR = 60;
  localparam int MIN_PER_DAY = 1440;
  localparam logic [7:0] SUNDAY_MASK = 8'h01;

endpackage : rcs_pkg

/* dv/rcs_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rcs_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // ----------------------------
  // one apb transfer
  // ----------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines stop showing the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : rcs_host
`default_nettype wire

/* dv/rcs_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module rcs_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mains_fail_start_req,
  input wire logic nvm_save,
  input wire logic service_pending,
  input wire logic anomaly_warning,
  input wire logic anomaly_unload,
  input wire logic anomaly_alarm,
  input wire logic gen_inhibit,
  input wire logic test_run,
  input wire logic auto_start
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------
  // properties
  // ----------------------------
  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_map: assert property (pready |-> pslverr == (paddr > rcs_pkg::OFF_FRAC))
    else $error("pslverr wrong for address");
  a_unmap_zero: assert property (pready && !pwrite && paddr > rcs_pkg::OFF_FRAC
    |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_save_pulse: assert property (nvm_save |=> !nvm_save)
    else $error("save pulse too long");
  a_anom_class: assert property ($onehot0({anomaly_warning, anomaly_unload, anomaly_alarm}))
    else $error("more than one anomaly class");
  a_anom_pend: assert property ((anomaly_warning || anomaly_unload || anomaly_alarm)
    |-> $past(service_pending))
    else $error("anomaly without pending request");
  a_alarm_inhibit: assert property (anomaly_alarm |-> ##[0:2] gen_inhibit)
    else $error("alarm without inhibit");
  a_auto_gate: assert property (!mains_fail_start_req [*5] |-> !auto_start)
    else $error("auto start without mains request");
  a_pend_clear: assert property ($fell(service_pending)
    |-> $past(psel && penable && pwrite && pready && paddr == rcs_pkg::OFF_SVC_IVL))
    else $error("request cleared without interval write");
  c_test: cover property ($rose(test_run));
  c_auto: cover property ($rose(auto_start));
  c_alarm: cover property ($rose(anomaly_alarm));
endmodule : rcs_top_chk
`default_nettype wire

bind rcs_top rcs_top_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mains_fail_start_req(mains_fail_start_req), .nvm_save(nvm_save),
  .service_pending(service_pending), .anomaly_warning(anomaly_warning),
  .anomaly_unload(anomaly_unload), .anomaly_alarm(anomaly_alarm),
  .gen_inhibit(gen_inhibit), .test_run(test_run), .auto_start(auto_start)
);

/* dv/test_runtime_counters_weekly_scheduler.sv */
`timescale 1ns/1ps
`default_nettype none
module test_runtime_counters_weekly_scheduler;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  logic minute_tick = 1'b0;
  logic [2:0] rtc_weekday = 3'h0;
  logic [10:0] rtc_minute_of_day = 11'h0;
  logic generator_breaker = 1'b0;
  logic engine_running = 1'b0;
  logic [15:0] p_active = 16'h0;
  logic [15:0] q_reactive = 16'h0;
  logic mode_off_reset = 1'b0;
  logic mains_fail_start_req = 1'b0;
  logic nvm_save, service_pending, anomaly_warning, anomaly_unload, anomaly_alarm;
  logic gen_inhibit, test_run, auto_start;
  int num_errors = 0;
  int compares = 0;
  int saves = 0;
  int s0;

  always #50 pclk = ~pclk;
  always @(posedge pclk) if (nvm_save === 1'b1) saves++;

  rcs_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  rcs_top #(.CNT_W(32), .MIN_TICK_CYCLES(10)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .minute_tick(minute_tick),
    .rtc_weekday(rtc_weekday), .rtc_minute_of_day(rtc_minute_of_day),
    .generator_breaker(generator_breaker), .engine_running(engine_running),
    .p_active(p_active), .q_reactive(q_reactive), .mode_off_reset(mode_off_reset),
    .mains_fail_start_req(mains_fail_start_req), .nvm_save(nvm_save),
    .service_pending(service_pending), .anomaly_warning(anomaly_warning),
    .anomaly_unload(anomaly_unload), .anomaly_alarm(anomaly_alarm),
    .gen_inhibit(gen_inhibit), .test_run(test_run), .auto_start(auto_start));

  // ----------------------------
  // helpers
  // ----------------------------
  task automatic stop_test;
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFFFFFF);
    u_host.xfer(1'b0, a, 32'h0, q, e);
    chk(q & m, x);
  endtask : rd

  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask : settle

  task automatic tick(input int n);
    repeat (n)
    begin
      minute_tick <= 1'b1;
      repeat (4) @(posedge pclk);
      minute_tick <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask : tick

  task automatic saved;
    chk(32'(saves != s0), 32'h1);
  endtask : saved

  task automatic sc(input logic [2:0] d, input logic [10:0] m, input logic t, input logic a);
    rtc_weekday <= d;
    rtc_minute_of_day <= m;
    tick(1);
    settle;
    chk({30'h0, test_run, auto_start}, {30'h0, t, a});
  endtask : sc

  initial
  begin
    repeat (10000) @(posedge pclk);
    num_errors++;
    stop_test;
  end

  // ----------------------------
  // tests
  // ----------------------------
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(rcs_pkg::OFF_STATUS, 32'h0);
    u_host.xfer(1'b0, 8'h58, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    s0 = saves;
    tick(5);
    chk(32'(saves - s0), 32'h0);
    rd(rcs_pkg::OFF_FRAC, 32'h5000, 32'h3F000);
    generator_breaker <= 1'b1;
    p_active <= 16'h0064;
    q_reactive <= 16'hFFF9;
    settle;
    tick(1);
    p_active <= 16'hFFCE;
    q_reactive <= 16'h0003;
    settle;
    tick(1);
    generator_breaker <= 1'b0;
    p_active <= 16'h0009;
    q_reactive <= 16'h0009;
    settle;
    tick(1);
    rd(rcs_pkg::OFF_KWH_PART, 32'h64);
    rd(rcs_pkg::OFF_KWH_TOT, 32'h64);
    rd(rcs_pkg::OFF_KVARH_PART, 32'hA);
    s0 = saves;
    wr(rcs_pkg::OFF_CLEAR, 32'h1F);
    settle;
    saved;
    rd(rcs_pkg::OFF_KWH_PART, 32'h0);
    rd(rcs_pkg::OFF_KWH_TOT, 32'h64);
    rd(rcs_pkg::OFF_KVARH_PART, 32'h0);
    rd(rcs_pkg::OFF_KVARH_TOT, 32'hA);
    for (int i = 0; i < 3; i++)
    begin
      wr(rcs_pkg::OFF_CTRL, 32'(i));
      s0 = saves;
      wr(rcs_pkg::OFF_SVC_IVL, 32'h1);
      settle;
      saved;
      s0 = saves;
      engine_running <= 1'b1;
      settle;
      saved;
      tick(60);
      settle;
      rd(rcs_pkg::OFF_STATUS, {28'h0, 3'h1 << i, 1'b1}, 32'hF);
      chk(32'(gen_inhibit), 32'(i == 2));
      s0 = saves;
      engine_running <= 1'b0;
      settle;
      saved;
      wr(rcs_pkg::OFF_SVC_IVL, 32'h0);
      settle;
      rd(rcs_pkg::OFF_STATUS, 32'h0, 32'hF);
    end
    rd(rcs_pkg::OFF_ENG_PART, 32'h3);
    rd(rcs_pkg::OFF_ENG_TOT, 32'h3);
    rd(rcs_pkg::OFF_STARTS, 32'h3);
    rd(rcs_pkg::OFF_LOAD_HRS, 32'h0);
    s0 = saves;
    mode_off_reset <= 1'b1;
    settle;
    saved;
    mode_off_reset <= 1'b0;
    wr(rcs_pkg::OFF_TEST_DAYS, 32'h2);
    wr(rcs_pkg::OFF_TEST_START, 32'h258);
    wr(rcs_pkg::OFF_TEST_DUR, 32'h1E);
    wr(rcs_pkg::OFF_AUTO_DAYS, 32'h2);
    wr(rcs_pkg::OFF_AUTO_START, 32'h528);
    wr(rcs_pkg::OFF_AUTO_END, 32'h78);
    mains_fail_start_req <= 1'b1;
    sc(3'h1, 11'h257, 1'b0, 1'b0);
    engine_running <= 1'b1;
    settle;
    engine_running <= 1'b0;
    sc(3'h1, 11'h258, 1'b1, 1'b0);
    sc(3'h1, 11'h275, 1'b1, 1'b0);
    sc(3'h1, 11'h276, 1'b0, 1'b0);
    sc(3'h2, 11'h262, 1'b0, 1'b0);
    sc(3'h0, 11'h532, 1'b0, 1'b0);
    sc(3'h1, 11'h532, 1'b0, 1'b1);
    sc(3'h2, 11'h03C, 1'b0, 1'b1);
    sc(3'h2, 11'h082, 1'b0, 1'b0);
    sc(3'h2, 11'h532, 1'b0, 1'b0);
    sc(3'h1, 11'h03C, 1'b0, 1'b0);
    mains_fail_start_req <= 1'b0;
    sc(3'h1, 11'h532, 1'b0, 1'b0);
    rd(rcs_pkg::OFF_PWR_HRS, 32'h3);
    stop_test;
  end
endmodule : test_runtime_counters_weekly_scheduler
`default_nettype wire
